/* File: rtl/rx_status_pkg.sv */
// Shared constants for the receive-port status register bank.
// Assumes an 8-bit register space reached through a serial control bus front end.
package rx_status_pkg;

  // Port count and widths
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [ADDR_W-1:0] RECEIVE_PORT_STATUS_ONE_ADDR = 8'h4D;
  localparam logic [ADDR_W-1:0] RECEIVE_PORT_STATUS_TWO_ADDR = 8'h4E;

  // Reset values
  localparam logic [DATA_W-1:0] PORT_SELECT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // Port select fields
  localparam int SEL_PHYS_MSB = 7;
  localparam int SEL_PHYS_LSB = 6;
  localparam int SEL_READ_MSB = 5;
  localparam int SEL_READ_LSB = 4;
  localparam int SEL_WRITE_MSB = 3;
  localparam int SEL_WRITE_LSB = 0;
  localparam logic [PORT_W-1:0] LOCAL_PHYS_PORT = 2'h0;

  // Status one fields
  localparam int ST1_PORT_MSB = 7;
  localparam int ST1_PORT_LSB = 6;
  localparam int ST1_CRC_BIT = 5;
  localparam int ST1_LOCK_CHG_BIT = 4;
  localparam int ST1_CTRL_ERR_BIT = 3;
  localparam int ST1_PARITY_BIT = 2;
  localparam int ST1_PASS_BIT = 1;
  localparam int ST1_LOCK_BIT = 0;

endpackage

/* File: rtl/sticky_flag.sv */
// Single sticky status flag with set-over-clear priority.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/1ps

module sticky_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic set,
  input wire logic clear,
  // State
  output logic flag
);

  // A set in the clearing cycle keeps the flag, so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule

/* File: rtl/rx_port_status_flags.sv */
// Per-port status register bank of a four-port receive hub: port select,
// first status register with sticky event flags, pass-through of the second.
// Assumes register strobes come from a serial control bus front end on CLK,
// and event inputs are one-cycle pulses or levels synchronous to CLK.
`timescale 1ns/1ps

// Operation
// - Bit 5 sets on a forward control-channel CRC error, holds, and clears when read.
// - Bit 4 sets whenever lock state changed since the last read and clears when read.
// - With enhanced errors off, bit 3 flags a control-channel sequence error and clears on read.
// - With enhanced errors on, bit 3 flags any channel error and clears only on a detail read.
// - Bit 2 is 1 while parity errors exceed the threshold and drops only when counters clear.
// - Bit 1 shows the live pass indication from the pass criteria.
// - Bit 0 shows the live receiver lock state.
// - Status registers are per-port copies chosen by the port select register at 0x4C.
// - Bits 7:6 of the first status register return the selected read port number.
module rx_port_status_flags
  import rx_status_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register access strobes
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  // Control-channel events, one bit per port
  input wire logic [NUM_PORTS-1:0] CTRL_CHAN_CRC_ERR,
  input wire logic [NUM_PORTS-1:0] CTRL_CHAN_SEQUENCE_ERR,
  input wire logic [NUM_PORTS-1:0] CTRL_CHAN_ANY_ERR,
  input wire logic [NUM_PORTS-1:0] ENHANCED_ERR_ENABLE,
  input wire logic [NUM_PORTS-1:0] CTRL_CHAN_ERR_DETAIL_READ,
  // Receiver state, one bit per port
  input wire logic [NUM_PORTS-1:0] RECEIVER_LOCKED,
  input wire logic [NUM_PORTS-1:0] PORT_PASS,
  input wire logic [NUM_PORTS-1:0] PARITY_OVER_THRESHOLD,
  input wire logic [NUM_PORTS-1:0] PARITY_ERR_COUNTER_CLEAR,
  // Second status register bytes, port 0 in the low byte
  input wire logic [NUM_PORTS*DATA_W-1:0] STATUS_TWO_BYTES,
  output logic [NUM_PORTS-1:0] STATUS_TWO_READ,
  // Port select state
  output logic [PORT_W-1:0] READ_PORT,
  output logic [NUM_PORTS-1:0] WRITE_PORT_ENABLE
);

  // True when an access strobe targets the given offset
  function automatic logic addr_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offset);
    addr_hit = strobe && (addr == offset);
  endfunction

  // True when the selected read port equals the given index
  function automatic logic port_hit(input logic [PORT_W-1:0] sel, input int idx);
    port_hit = (sel == idx[PORT_W-1:0]);
  endfunction

  logic sel_wr;
  logic sel_rd;
  logic st1_rd;
  logic st2_rd;
  logic [NUM_PORTS-1:0] st1_rd_port;
  logic [NUM_PORTS-1:0] locked_q;
  logic [NUM_PORTS-1:0] lock_edge;
  logic [NUM_PORTS-1:0] pass_q;
  logic [NUM_PORTS-1:0] crc_flag;
  logic [NUM_PORTS-1:0] lock_chg_flag;
  logic [NUM_PORTS-1:0] seq_flag;
  logic [NUM_PORTS-1:0] any_flag;
  logic [NUM_PORTS-1:0] parity_flag;
  logic [NUM_PORTS-1:0] ctrl_err_bit;
  logic [DATA_W-1:0] status_one [NUM_PORTS];
  logic [DATA_W-1:0] next_rdata;

  // Access decode
  assign sel_wr = addr_hit(REG_WR, REG_ADDR, PORT_SELECT_ADDR);
  assign sel_rd = addr_hit(REG_RD, REG_ADDR, PORT_SELECT_ADDR);
  assign st1_rd = addr_hit(REG_RD, REG_ADDR, RECEIVE_PORT_STATUS_ONE_ADDR);
  assign st2_rd = addr_hit(REG_RD, REG_ADDR, RECEIVE_PORT_STATUS_TWO_ADDR);

  // Port select register: read port and write enables
  // Writes to any other offset are dropped; the status bytes hold no writable bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      READ_PORT <= PORT_SELECT_RESET[SEL_READ_MSB:SEL_READ_LSB];
      WRITE_PORT_ENABLE <= PORT_SELECT_RESET[SEL_WRITE_MSB:SEL_WRITE_LSB];
    end else if (sel_wr) begin
      READ_PORT <= REG_WDATA[SEL_READ_MSB:SEL_READ_LSB];
      WRITE_PORT_ENABLE <= REG_WDATA[SEL_WRITE_MSB:SEL_WRITE_LSB];
    end
  end

  // Live receiver levels sampled once per cycle; the status byte shows these copies
  // Reset clears them, so a port already locked reports one lock change after reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      locked_q <= '0;
      pass_q <= '0;
    end else begin
      locked_q <= RECEIVER_LOCKED;
      pass_q <= PORT_PASS;
    end
  end

  // Lock level differs from its last sample: the lock state changed this cycle
  assign lock_edge = RECEIVER_LOCKED ^ locked_q;

  // Per-port copies of the first status register
  // Every flag lets a set win over a clear in the same cycle, so no event is lost
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Read of this port's copy
    assign st1_rd_port[p] = st1_rd && port_hit(READ_PORT, p);

    // CRC error, clear on read
    sticky_flag u_crc (
      .clk(CLK),
      .rst(RST),
      .set(CTRL_CHAN_CRC_ERR[p]),
      .clear(st1_rd_port[p]),
      .flag(crc_flag[p])
    );

    // Lock state differs from the last sample
    sticky_flag u_lock_chg (
      .clk(CLK),
      .rst(RST),
      .set(lock_edge[p]),
      .clear(st1_rd_port[p]),
      .flag(lock_chg_flag[p])
    );

    // Sequence error, used with enhanced errors off
    sticky_flag u_seq (
      .clk(CLK),
      .rst(RST),
      .set(CTRL_CHAN_SEQUENCE_ERR[p] && !ENHANCED_ERR_ENABLE[p]),
      .clear(st1_rd_port[p]),
      .flag(seq_flag[p])
    );

    // Any control-channel error, cleared by the detail register read only
    sticky_flag u_any (
      .clk(CLK),
      .rst(RST),
      .set(CTRL_CHAN_ANY_ERR[p] && ENHANCED_ERR_ENABLE[p]),
      .clear(CTRL_CHAN_ERR_DETAIL_READ[p]),
      .flag(any_flag[p])
    );

    // Parity threshold exceeded, held until the counters clear
    sticky_flag u_parity (
      .clk(CLK),
      .rst(RST),
      .set(PARITY_OVER_THRESHOLD[p]),
      .clear(PARITY_ERR_COUNTER_CLEAR[p]),
      .flag(parity_flag[p])
    );

    // Bit 3 meaning follows the enhanced error setting
    // Both flags are kept, but a first status read with enhanced errors on still clears a pending sequence error unseen
    assign ctrl_err_bit[p] = ENHANCED_ERR_ENABLE[p] ? any_flag[p] : seq_flag[p];
  end

  // Assembled first status byte of every port, one process for the whole array
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      status_one[p] = STATUS_RESET;
      status_one[p][ST1_PORT_MSB:ST1_PORT_LSB] = READ_PORT;
      status_one[p][ST1_CRC_BIT] = crc_flag[p];
      status_one[p][ST1_LOCK_CHG_BIT] = lock_chg_flag[p];
      status_one[p][ST1_CTRL_ERR_BIT] = ctrl_err_bit[p];
      status_one[p][ST1_PARITY_BIT] = parity_flag[p];
      status_one[p][ST1_PASS_BIT] = pass_q[p];
      status_one[p][ST1_LOCK_BIT] = locked_q[p];
    end
  end

  // Read data selection by offset and selected port; unmapped offsets read as zero
  // The byte is taken before the clear, so a read reports the flags that it clears
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (sel_rd) begin
      next_rdata[SEL_PHYS_MSB:SEL_PHYS_LSB] = LOCAL_PHYS_PORT;
      next_rdata[SEL_READ_MSB:SEL_READ_LSB] = READ_PORT;
      next_rdata[SEL_WRITE_MSB:SEL_WRITE_LSB] = WRITE_PORT_ENABLE;
    end else if (st1_rd) begin
      next_rdata = status_one[READ_PORT];
    end else if (st2_rd) begin
      next_rdata = STATUS_TWO_BYTES[READ_PORT*DATA_W +: DATA_W];
    end
  end

  // Registered read answer, one cycle after the strobe
  // Read data holds between reads, so the front end may shift it out at its own pace
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= STATUS_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // Tell the second register's owner which copy was read
  // Registered so the pulse lines up with the read answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      STATUS_TWO_READ <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        STATUS_TWO_READ[p] <= st2_rd && port_hit(READ_PORT, p);
      end
    end
  end

endmodule

/* File: verif/reg_host.sv */
// Host model: single-byte register reads and writes on the strobe bus.
// Assumes the bench calls its tasks; signals move 1 ns after a CLK edge.
`timescale 1ns/1ps
module reg_host (
  // Clock and answer
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Strobes
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    {addr, wdata, wr, rd} = '0;
  end
  // Write; released lines show the inverse so stale values are not trusted
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask
  // n back-to-back reads; returns the last answer
  task automatic rd_byte(input logic [7:0] a, input int n, output logic [7:0] v);
    @(posedge clk) #1;
    addr = a;
    rd = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    v = rvalid ? rdata : 8'hXX;
  endtask
endmodule

/* File: verif/rx_flags_asserts.sv */
// Checker for the status bank: read timing and status byte contents.
// Assumes nothing about where the bank sits; the bind below attaches it to every bank instance.
`timescale 1ns/1ps
module rx_flags_chk
  import rx_status_pkg::*;
(
  // Clock, reset and bus
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Port state
  input wire logic [NUM_PORTS-1:0] CTRL_CHAN_CRC_ERR,
  input wire logic [NUM_PORTS-1:0] RECEIVER_LOCKED,
  input wire logic [NUM_PORTS-1:0] PORT_PASS,
  input wire logic [NUM_PORTS-1:0] STATUS_TWO_READ,
  input wire logic [PORT_W-1:0] READ_PORT
);
  logic rd1;
  logic [NUM_PORTS-1:0] lk;
  logic [NUM_PORTS-1:0] ps;
  logic [NUM_PORTS-1:0] ev;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Read of the first status register
  assign rd1 = REG_RD && REG_ADDR == RECEIVE_PORT_STATUS_ONE_ADDR;
  // Live inputs one cycle late, as the status byte shows them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      {lk, ps, ev} <= '0;
    end else begin
      {lk, ps, ev} <= {RECEIVER_LOCKED, PORT_PASS, CTRL_CHAN_CRC_ERR};
    end
  end
  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("no read answer");
  a_port_number: assert property (rd1 |=> REG_RDATA[7:6] == $past(READ_PORT))
    else $error("port field wrong");
  a_lock_live: assert property (rd1 |=> REG_RDATA[0] == $past(lk[READ_PORT]))
    else $error("lock bit wrong");
  a_pass_live: assert property (rd1 |=> REG_RDATA[1] == $past(ps[READ_PORT]))
    else $error("pass bit wrong");
  a_crc_sets: assert property (rd1 && ev[READ_PORT] |=> REG_RDATA[5])
    else $error("crc flag lost");
  a_crc_clears: assert property (rd1 && !CTRL_CHAN_CRC_ERR[READ_PORT] ##1 rd1
    |=> !REG_RDATA[5]) else $error("crc flag not cleared");
  a_crc_kept: assert property (rd1 && CTRL_CHAN_CRC_ERR[READ_PORT] ##1 rd1
    |=> REG_RDATA[5]) else $error("crc event lost in read");
  a_two_read: assert property (REG_RD && REG_ADDR == RECEIVE_PORT_STATUS_TWO_ADDR
    |=> STATUS_TWO_READ == 4'h1 << $past(READ_PORT)) else $error("second read pulse");
endmodule
bind rx_port_status_flags rx_flags_chk rx_flags_chk_inst (.CLK(CLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CTRL_CHAN_CRC_ERR(CTRL_CHAN_CRC_ERR), .RECEIVER_LOCKED(RECEIVER_LOCKED),
  .PORT_PASS(PORT_PASS), .STATUS_TWO_READ(STATUS_TWO_READ), .READ_PORT(READ_PORT));

/* File: verif/tb_rx_port_status_flags.sv */
// Self-checking bench for the receive-port status bank.
// Assumes the host model drives the bus; events move 1 ns after CLK.
`timescale 1ns/1ps
`define CMP(g, e) \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error %0t: got %h exp %h", $time, g, e); \
  end
module tb_rx_port_status_flags;
  import rx_status_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid;
  logic [3:0] crc = '0, seq = '0, anyerr = '0, enh = '0, det = '0, par = '0, pclr = '0;
  logic [3:0] lock = 4'h5, pass = 4'h3, two_rd, wen;
  logic [1:0] rport;
  int err_count = 0, comparisons = 0, cyc = 0;
  // Rows: select byte, offset, expected read byte
  logic [23:0] rows [7] = '{24'h014D13, 24'h124D42, 24'h244D91, 24'h384DC0,
    24'h384C38, 24'h384EA4, 24'h385500};
  reg_host reg_host_inst (.clk(CLK), .rdata(rdata), .rvalid(rvalid), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  rx_port_status_flags rx_port_status_flags_inst (.CLK(CLK), .RST(RST), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .CTRL_CHAN_CRC_ERR(crc), .CTRL_CHAN_SEQUENCE_ERR(seq), .CTRL_CHAN_ANY_ERR(anyerr),
    .ENHANCED_ERR_ENABLE(enh), .CTRL_CHAN_ERR_DETAIL_READ(det), .RECEIVER_LOCKED(lock),
    .PORT_PASS(pass), .PARITY_OVER_THRESHOLD(par), .PARITY_ERR_COUNTER_CLEAR(pclr),
    .STATUS_TWO_BYTES(32'hA4B3C2D1), .STATUS_TWO_READ(two_rd), .READ_PORT(rport),
    .WRITE_PORT_ENABLE(wen));
  always #25 CLK = ~CLK;
  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step();
    @(posedge CLK) #1;
  endtask
  // Read the first status register of the selected port and compare
  task automatic chk(input int n, input logic [7:0] e);
    reg_host_inst.rd_byte(RECEIVE_PORT_STATUS_ONE_ADDR, n, d);
    `CMP(d, e)
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    #1 RST = 0;
    foreach (rows[i]) begin
      reg_host_inst.wr_byte(PORT_SELECT_ADDR, rows[i][23:16]);
      reg_host_inst.rd_byte(rows[i][15:8], 1, d);
      `CMP(d, rows[i][7:0])
      `CMP(wen, rows[i][19:16])
    end
    reg_host_inst.wr_byte(PORT_SELECT_ADDR, 8'h12);
    step();
    crc = 4'h2;
    step();
    crc = 4'h0;
    chk(1, 8'h62);
    chk(1, 8'h42);
    // Event held through a double read survives the clear
    crc = 4'h2;
    chk(2, 8'h62);
    crc = 4'h0;
    chk(2, 8'h42);
    seq = 4'h2;
    anyerr = 4'h2;
    step();
    {seq, anyerr} = '0;
    chk(1, 8'h4A);
    chk(1, 8'h42);
    enh = 4'h2;
    chk(1, 8'h42);
    anyerr = 4'h2;
    step();
    anyerr = 4'h0;
    chk(1, 8'h4A);
    chk(1, 8'h4A);
    det = 4'h2;
    step();
    det = 4'h0;
    chk(1, 8'h42);
    lock = 4'h7;
    chk(1, 8'h53);
    chk(1, 8'h43);
    par = 4'h2;
    step();
    par = 4'h0;
    chk(1, 8'h47);
    chk(1, 8'h47);
    pclr = 4'h2;
    step();
    pclr = 4'h0;
    chk(1, 8'h43);
    // Sequence error while enhanced errors are on is refused
    seq = 4'h2;
    step();
    seq = 4'h0;
    chk(1, 8'h43);
    enh = 4'h0;
    chk(1, 8'h43);
    RST = 1'b1;
    step();
    `CMP({rport, wen, rdata, rvalid, two_rd}, 19'h0)
    RST = 1'b0;
    // Port 0 is locked when reset lets go, so one lock change is reported
    chk(1, 8'h13);
    chk(1, 8'h03);
    close_out();
  end
endmodule
